// ==== design/clpc_pkg.sv ====
// Purpose: Constants for the clock and low-power control block
// Assumes: 100 MHz mclk, plain strobe register port
// Notes: Offsets are word indexes on the register port
// Function
// - PLL multiplier field bits 13:8 decodes eight codes to x8..x50.
// - Oscillator wait field decodes sixteen codes to 2..524288 cycles.
// - System, peripheral, bus and flash clock dividers are set independently.
// - Bus clock pin carries the clock or a static high.
// - Memory clock pin carries its clock or a static high.
// - Each peripheral module has its own clock stop bit.
// - Sleep, all-clock stop, software standby and deep standby are supported.
// - Three power control modes apply in run, sleep and all-clock stop.
// - Low-power mode is entered only by the wait instruction after setup.
// - Sleep and all-clock stop exit only on an interrupt, into its handler.
// - Sleep halts the processor, the system clock and the main watchdog; everything else keeps running.
// - All-clock stop halts processor, memories, DMA and peripherals; oscillators run.
// - Independent watchdog runs; main watchdog stops in both modes.
// - Eight-bit timers 0 and 1 keep counting in both modes.
// - USB runs in sleep, stops without retention in all-clock stop.
// - Second RAM bank runs in sleep, stops retained in all-clock stop.
// - Standby select bit zero gives sleep or all-clock stop, one gives standby.
// - Enable bit picks all-clock stop over sleep on the wait instruction.
package clpc_pkg;
	localparam logic [3:0] ADDR_PLL = 4'h0;
	localparam logic [3:0] ADDR_OSCW = 4'h1;
	localparam logic [3:0] ADDR_DIV = 4'h2;
	localparam logic [3:0] ADDR_PINS = 4'h3;
	localparam logic [3:0] ADDR_STOP = 4'h4;
	localparam logic [3:0] ADDR_SBY = 4'h5;
	localparam logic [3:0] ADDR_OPC = 4'h6;
	localparam logic [3:0] ADDR_STAT = 4'h7;
	localparam int PLL_LSB = 8;
	localparam logic [15:0] PLL_RST = 16'h0700;
	localparam logic [7:0] OSCW_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [1:0] PINS_RST = 2'h0;
	localparam logic [31:0] STOP_RST = 32'hffff_ffff;
	localparam int SBY_STANDBY = 0;
	localparam int SBY_ALL_CLOCK_STOP_ENABLE = 1;
	localparam int SBY_DEEP = 2;
	localparam logic [2:0] OPC_HIGH = 3'h0;
	localparam logic [2:0] OPC_LOW1 = 3'h6;
	localparam logic [2:0] OPC_LOW2 = 3'h7;
	localparam int MODULES = 32;
	typedef enum logic [2:0] {CLPC_RUN, CLPC_SLEEP, CLPC_ALLSTOP, CLPC_STANDBY, CLPC_DEEP} clpc_mode_t;
endpackage : clpc_pkg

// ==== design/clpc_div.sv ====
// Purpose: Programmable clock-enable divider
// Assumes: Ratio is 2**sel[2:0] (sel bit 3 is ignored), sel 0 passes every cycle
// Notes: Output is a one-cycle enable pulse
`timescale 1ns/1ps
module clpc_div (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] sel,
	output logic en
);
	logic [7:0] cnt_reg;
	logic [7:0] lim;
	wire hit = (cnt_reg >= lim);
	assign lim = 8'((9'h1 << sel[2:0]) - 9'h1);
	// Count up to the limit and pulse once per period
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			en <= 1'b0;
		end else begin
			cnt_reg <= hit ? 8'h00 : cnt_reg + 8'h01;
			en <= hit;
		end
	end
endmodule : clpc_div

// ==== design/clpc_wait.sv ====
// Purpose: Oscillator wait-time counter
// Assumes: Code held stable while counting
// Notes: Codes above 0x0f are illegal and treated as the longest wait
`timescale 1ns/1ps
module clpc_wait (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [4:0] code,
	output logic done
);
	logic [19:0] cnt_reg;
	logic [19:0] target;
	logic busy_reg;
	// Wait table decode
	always_comb begin
		case (code)
			5'h00: target = 20'd2;
			5'h01: target = 20'd4;
			5'h02: target = 20'd8;
			5'h03: target = 20'd16;
			5'h04: target = 20'd32;
			5'h05: target = 20'd64;
			5'h06: target = 20'd512;
			5'h07: target = 20'd1024;
			5'h08: target = 20'd2048;
			5'h09: target = 20'd4096;
			5'h0a: target = 20'd16384;
			5'h0b: target = 20'd32768;
			5'h0c: target = 20'd65536;
			5'h0d: target = 20'd131072;
			5'h0e: target = 20'd262144;
			default: target = 20'd524288;
		endcase
	end
	// Done goes high after the selected number of cycles
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 20'h0;
			busy_reg <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			cnt_reg <= 20'h1;
			busy_reg <= 1'b1;
			done <= 1'b0;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 20'h1;
			if (cnt_reg == target) begin
				busy_reg <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule : clpc_wait

// ==== design/clpc_top.sv ====
// Purpose: Clock dividers, pin output control, module stop and low-power mode sequencing
// Assumes: wait_instr is a one-cycle pulse from the processor; irq_req is a level
// Notes: Gating outputs are enables, 1 means the unit is clocked
`timescale 1ns/1ps
module clpc_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	input wire logic wait_instr,
	input wire logic irq_req,
	input wire logic osc_restart,
	output logic system_clock_en,
	output logic peripheral_clock_b_en,
	output logic bus_clock_en,
	output logic flash_if_clock_en,
	output logic bclk_pin,
	output logic sync_memory_clock_pin,
	output logic [31:0] module_clk_en,
	output logic cpu_run,
	output logic cpu_irq_vector,
	output logic ram_en,
	output logic second_ram_bank_en,
	output logic dma_unit_en,
	output logic transfer_controller_en,
	output logic flash_en,
	output logic usb_en,
	output logic usb_reset,
	output logic main_watchdog_en,
	output logic independent_watchdog_en,
	output logic eight_bit_timer_en,
	output logic osc_pll_en,
	output logic io_hold,
	output logic irq_detect_en,
	output logic [2:0] power_mode,
	output logic [5:0] pll_mult,
	output logic osc_stable
);
	logic [15:0] pll_control_reg;
	logic [7:0] main_osc_wait_control_reg;
	logic [15:0] div_reg;
	logic [1:0] pins_reg;
	logic [31:0] stop_reg;
	logic [2:0] sby_reg;
	logic [2:0] opc_reg;
	logic [31:0] rdata_next;
	clpc_pkg::clpc_mode_t mode_reg;
	clpc_pkg::clpc_mode_t mode_next;
	logic en_i;
	logic en_p;
	logic en_b;
	logic en_f;
	logic bclk_tog_reg;
	logic sync_memory_clock_tog_reg;
	logic osc_done;
	logic [5:0] pll_multiplier_sel;
	logic [5:0] mult_dec;

	// Register writes
	wire wr_pll = wr_stb && (addr == clpc_pkg::ADDR_PLL);
	wire wr_oscw = wr_stb && (addr == clpc_pkg::ADDR_OSCW);
	wire wr_div = wr_stb && (addr == clpc_pkg::ADDR_DIV);
	wire wr_pins = wr_stb && (addr == clpc_pkg::ADDR_PINS);
	wire wr_stop = wr_stb && (addr == clpc_pkg::ADDR_STOP);
	wire wr_sby = wr_stb && (addr == clpc_pkg::ADDR_SBY);
	wire wr_opc = wr_stb && (addr == clpc_pkg::ADDR_OPC);
	wire [4:0] main_osc_wait_sel = main_osc_wait_control_reg[4:0];
	wire standby_select_bit = sby_reg[clpc_pkg::SBY_STANDBY];
	wire all_clock_stop_enable = sby_reg[clpc_pkg::SBY_ALL_CLOCK_STOP_ENABLE];
	wire in_sleep = (mode_reg == clpc_pkg::CLPC_SLEEP);
	wire in_allstop = (mode_reg == clpc_pkg::CLPC_ALLSTOP);
	wire in_stby = (mode_reg == clpc_pkg::CLPC_STANDBY) || (mode_reg == clpc_pkg::CLPC_DEEP);
	wire run = (mode_reg == clpc_pkg::CLPC_RUN);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pll_control_reg <= clpc_pkg::PLL_RST;
			main_osc_wait_control_reg <= clpc_pkg::OSCW_RST;
			div_reg <= clpc_pkg::DIV_RST;
			pins_reg <= clpc_pkg::PINS_RST;
			stop_reg <= clpc_pkg::STOP_RST;
			sby_reg <= 3'h0;
			opc_reg <= clpc_pkg::OPC_HIGH;
		end else begin
			if (wr_pll)
				pll_control_reg <= wdata[15:0];
			if (wr_oscw)
				main_osc_wait_control_reg <= wdata[7:0];
			if (wr_div)
				div_reg <= wdata[15:0];
			if (wr_pins)
				pins_reg <= wdata[1:0];
			if (wr_stop)
				stop_reg <= wdata;
			if (wr_sby)
				sby_reg <= wdata[2:0];
			if (wr_opc && (wdata[2:0] == clpc_pkg::OPC_HIGH || wdata[2:0] == clpc_pkg::OPC_LOW1
				|| wdata[2:0] == clpc_pkg::OPC_LOW2))
				opc_reg <= wdata[2:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		if (addr == clpc_pkg::ADDR_PLL)
			rdata_next = {16'h0, pll_control_reg};
		else if (addr == clpc_pkg::ADDR_OSCW)
			rdata_next = {24'h0, main_osc_wait_control_reg};
		else if (addr == clpc_pkg::ADDR_DIV)
			rdata_next = {16'h0, div_reg};
		else if (addr == clpc_pkg::ADDR_PINS)
			rdata_next = {30'h0, pins_reg};
		else if (addr == clpc_pkg::ADDR_STOP)
			rdata_next = stop_reg;
		else if (addr == clpc_pkg::ADDR_SBY)
			rdata_next = {29'h0, sby_reg};
		else if (addr == clpc_pkg::ADDR_OPC)
			rdata_next = {29'h0, opc_reg};
		else if (addr == clpc_pkg::ADDR_STAT)
			rdata_next = {24'h0, osc_stable, 4'h0, 3'(mode_reg)};
		else
			rdata_next = 32'h0;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata <= 32'h0;
		else
			rdata <= rd_stb ? rdata_next : 32'h0;
	end

	// Four independent divider chains, one nibble each
	clpc_div u_div_i (.mclk(mclk), .rst(rst), .sel(div_reg[3:0]), .en(en_i));
	clpc_div u_div_p (.mclk(mclk), .rst(rst), .sel(div_reg[7:4]), .en(en_p));
	clpc_div u_div_b (.mclk(mclk), .rst(rst), .sel(div_reg[11:8]), .en(en_b));
	clpc_div u_div_f (.mclk(mclk), .rst(rst), .sel(div_reg[15:12]), .en(en_f));

	// Oscillator wait restarts on a new code or an external restart
	clpc_wait u_wait (.mclk(mclk), .rst(rst), .start(wr_oscw || osc_restart), .code(main_osc_wait_sel),
		.done(osc_done));

	// Multiplier decode; illegal codes give zero
	assign pll_multiplier_sel = pll_control_reg[clpc_pkg::PLL_LSB +: 6];
	always_comb begin
		case (pll_multiplier_sel)
			6'h07: mult_dec = 6'd8;
			6'h08: mult_dec = 6'd10;
			6'h0b: mult_dec = 6'd12;
			6'h0f: mult_dec = 6'd16;
			6'h13: mult_dec = 6'd20;
			6'h17: mult_dec = 6'd24;
			6'h18: mult_dec = 6'd25;
			6'h31: mult_dec = 6'd50;
			default: mult_dec = 6'd0;
		endcase
	end

	// Mode sequencer: entry only on the wait instruction, exit only on interrupt
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			clpc_pkg::CLPC_RUN: begin
				if (wait_instr) begin
					if (standby_select_bit)
						mode_next = sby_reg[clpc_pkg::SBY_DEEP] ? clpc_pkg::CLPC_DEEP : clpc_pkg::CLPC_STANDBY;
					else if (all_clock_stop_enable)
						mode_next = clpc_pkg::CLPC_ALLSTOP;
					else
						mode_next = clpc_pkg::CLPC_SLEEP;
				end
			end
			default: begin
				if (irq_req)
					mode_next = clpc_pkg::CLPC_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			mode_reg <= clpc_pkg::CLPC_RUN;
		else
			mode_reg <= mode_next;
	end

	// Registered clock enables and pin drives; pins toggle once per bus enable, giving a clock at half that rate
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			system_clock_en <= 1'b0;
			peripheral_clock_b_en <= 1'b0;
			bus_clock_en <= 1'b0;
			flash_if_clock_en <= 1'b0;
			bclk_tog_reg <= 1'b0;
			sync_memory_clock_tog_reg <= 1'b0;
			bclk_pin <= 1'b1;
			sync_memory_clock_pin <= 1'b1;
			module_clk_en <= 32'h0;
		end else begin
			system_clock_en <= en_i && run;
			peripheral_clock_b_en <= en_p && (run || in_sleep);
			bus_clock_en <= en_b && (run || in_sleep);
			flash_if_clock_en <= en_f && (run || in_sleep);
			if (en_b)
				bclk_tog_reg <= ~bclk_tog_reg;
			if (en_b)
				sync_memory_clock_tog_reg <= ~sync_memory_clock_tog_reg;
			bclk_pin <= pins_reg[0] ? bclk_tog_reg : 1'b1;
			sync_memory_clock_pin <= pins_reg[1] ? sync_memory_clock_tog_reg : 1'b1;
			module_clk_en <= (run || in_sleep) ? ~stop_reg : 32'h0;
		end
	end

	// Per-unit states for each mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cpu_run <= 1'b0;
			cpu_irq_vector <= 1'b0;
			ram_en <= 1'b0;
			second_ram_bank_en <= 1'b0;
			dma_unit_en <= 1'b0;
			transfer_controller_en <= 1'b0;
			flash_en <= 1'b0;
			usb_en <= 1'b0;
			usb_reset <= 1'b0;
			main_watchdog_en <= 1'b0;
			independent_watchdog_en <= 1'b0;
			eight_bit_timer_en <= 1'b0;
			osc_pll_en <= 1'b0;
			io_hold <= 1'b0;
			irq_detect_en <= 1'b0;
			power_mode <= clpc_pkg::OPC_HIGH;
			pll_mult <= 6'h0;
			osc_stable <= 1'b0;
		end else begin
			cpu_run <= run;
			cpu_irq_vector <= !run && irq_req;
			ram_en <= run || in_sleep;
			second_ram_bank_en <= run || in_sleep;
			dma_unit_en <= run || in_sleep;
			transfer_controller_en <= run || in_sleep;
			flash_en <= run || in_sleep;
			usb_en <= run || in_sleep;
			usb_reset <= in_allstop;
			main_watchdog_en <= run;
			independent_watchdog_en <= (mode_reg != clpc_pkg::CLPC_DEEP);
			eight_bit_timer_en <= run || in_sleep || in_allstop;
			osc_pll_en <= !in_stby;
			io_hold <= in_allstop || in_stby;
			irq_detect_en <= 1'b1;
			power_mode <= opc_reg;
			pll_mult <= mult_dec;
			if (osc_restart)
				osc_stable <= 1'b0;
			else if (osc_done)
				osc_stable <= 1'b1;
		end
	end

	a_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
		(run && wait_instr && !standby_select_bit && !all_clock_stop_enable) |=> in_sleep)
		else $error("Sleep not entered");
	a_allstop_entry: assert property (@(posedge mclk) disable iff (rst)
		(run && wait_instr && !standby_select_bit && all_clock_stop_enable) |=> in_allstop)
		else $error("All-clock stop not entered");
	a_standby_entry: assert property (@(posedge mclk) disable iff (rst)
		(run && wait_instr && standby_select_bit) |=> in_stby)
		else $error("Standby not entered");
	a_no_spurious: assert property (@(posedge mclk) disable iff (rst)
		(run && !wait_instr) |=> run)
		else $error("Mode left without wait");
	a_irq_exit: assert property (@(posedge mclk) disable iff (rst)
		((in_sleep || in_allstop) && irq_req) |=> run ##1 cpu_run)
		else $error("Interrupt did not wake");
	a_irq_vector: assert property (@(posedge mclk) disable iff (rst)
		(!run && irq_req) |=> cpu_irq_vector)
		else $error("Wake-up did not enter handler");
	a_cpu_halt: assert property (@(posedge mclk) disable iff (rst)
		in_sleep |=> !cpu_run && usb_en && second_ram_bank_en)
		else $error("Sleep unit states wrong");
	a_allstop_units: assert property (@(posedge mclk) disable iff (rst)
		in_allstop |=> !ram_en && !dma_unit_en && osc_pll_en && eight_bit_timer_en && !usb_en)
		else $error("All-clock stop unit states wrong");
	a_watchdogs: assert property (@(posedge mclk) disable iff (rst)
		(in_sleep || in_allstop) |=> !main_watchdog_en && independent_watchdog_en)
		else $error("Watchdog states wrong");
	a_bclk_high: assert property (@(posedge mclk) disable iff (rst)
		!pins_reg[0] ##1 !pins_reg[0] |-> bclk_pin)
		else $error("Bus clock pin not high");
	a_sync_memory_clock_high: assert property (@(posedge mclk) disable iff (rst)
		!pins_reg[1] ##1 !pins_reg[1] |-> sync_memory_clock_pin)
		else $error("Memory clock pin not high");
	a_module_stop: assert property (@(posedge mclk) disable iff (rst)
		run |=> (module_clk_en == ~$past(stop_reg)))
		else $error("Module clock enables wrong");
	a_power_legal: assert property (@(posedge mclk) disable iff (rst)
		(power_mode == clpc_pkg::OPC_HIGH) || (power_mode == clpc_pkg::OPC_LOW1) || (power_mode == clpc_pkg::OPC_LOW2))
		else $error("Power mode code illegal");
	a_mult_x50: assert property (@(posedge mclk) disable iff (rst)
		(pll_multiplier_sel == 6'h31) |=> pll_mult == 6'd50)
		else $error("Multiplier decode wrong");
endmodule : clpc_top

// ==== dv/clpc_top_tb.sv ====
// Purpose: Self-checking bench for the clock and low-power control block
// Assumes: Strobe register port, read data one cycle after the read strobe
// Notes: Wait counts are compared relative to the shortest code, so fixed pipeline latency cancels out
`timescale 1ns/1ps
module clpc_top_tb;
	logic mclk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, wait_instr = 1'b0, irq_req = 1'b0, osc_restart = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, module_clk_en, rv;
	logic system_clock_en, peripheral_clock_b_en, bus_clock_en, flash_if_clock_en, bclk_pin, sync_memory_clock_pin;
	logic cpu_run, cpu_irq_vector, ram_en, second_ram_bank_en, dma_unit_en, transfer_controller_en, flash_en, usb_en;
	logic usb_reset, main_watchdog_en, independent_watchdog_en, eight_bit_timer_en, osc_pll_en, io_hold, irq_detect_en;
	logic osc_stable;
	logic [2:0] power_mode;
	logic [5:0] pll_mult;
	int err_count = 0, check_count = 0, cyc = 0;
	int ne[4];
	clpc_top u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .wait_instr(wait_instr), .irq_req(irq_req), .osc_restart(osc_restart),
		.system_clock_en(system_clock_en), .peripheral_clock_b_en(peripheral_clock_b_en),
		.bus_clock_en(bus_clock_en), .flash_if_clock_en(flash_if_clock_en), .bclk_pin(bclk_pin),
		.sync_memory_clock_pin(sync_memory_clock_pin), .module_clk_en(module_clk_en), .cpu_run(cpu_run),
		.cpu_irq_vector(cpu_irq_vector), .ram_en(ram_en), .second_ram_bank_en(second_ram_bank_en),
		.dma_unit_en(dma_unit_en), .transfer_controller_en(transfer_controller_en), .flash_en(flash_en),
		.usb_en(usb_en), .usb_reset(usb_reset), .main_watchdog_en(main_watchdog_en),
		.independent_watchdog_en(independent_watchdog_en), .eight_bit_timer_en(eight_bit_timer_en),
		.osc_pll_en(osc_pll_en), .io_hold(io_hold), .irq_detect_en(irq_detect_en), .power_mode(power_mode),
		.pll_mult(pll_mult), .osc_stable(osc_stable));
	// 100 MHz clock
	always #5 mclk = ~mclk;
	// Hang guard: the longest test needs well under this many cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr
	// Read data only stands in the cycle after the strobe, so it is sampled just after that edge
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic pulse_wait();
		@(posedge mclk);
		wait_instr <= 1'b1;
		@(posedge mclk);
		wait_instr <= 1'b0;
		tick(3);
	endtask : pulse_wait
	// Count enable pulses of the four dividers over 64 cycles
	task automatic count_en();
		ne = '{0, 0, 0, 0};
		tick(4);
		repeat (64) begin
			ne[0] += system_clock_en;
			ne[1] += peripheral_clock_b_en;
			ne[2] += bus_clock_en;
			ne[3] += flash_if_clock_en;
			tick(1);
		end
	endtask : count_en
	task automatic t_reset();
		rd(clpc_pkg::ADDR_PLL, rv); chk(rv, 32'h0000_0700);
		rd(clpc_pkg::ADDR_STOP, rv); chk(rv, 32'hffff_ffff);
		rd(clpc_pkg::ADDR_STAT, rv); chk({29'h0, rv[2:0]}, 32'h0);
		rd(4'h9, rv); chk(rv, 32'h0);
		chk({30'h0, bclk_pin, sync_memory_clock_pin}, 32'h3);
	endtask : t_reset
	task automatic t_pll();
		logic [5:0] code[9] = '{6'h07, 6'h08, 6'h0b, 6'h0f, 6'h13, 6'h17, 6'h18, 6'h31, 6'h00};
		int mult[9] = '{8, 10, 12, 16, 20, 24, 25, 50, 0};
		for (int k = 0; k < 9; k++) begin
			wr(clpc_pkg::ADDR_PLL, {18'h0, code[k], 8'h00});
			tick(2);
			chk({26'h0, pll_mult}, 32'(mult[k]));
		end
	endtask : t_pll
	// Settle times are measured from the restart pulse; the shortest code fixes the offset
	task automatic t_osc();
		int waits[11] = '{2, 4, 8, 16, 32, 64, 512, 1024, 2048, 4096, 16384};
		int n, base;
		for (int k = 0; k < 11; k++) begin
			wr(clpc_pkg::ADDR_OSCW, 32'(k));
			@(posedge mclk);
			osc_restart <= 1'b1;
			@(posedge mclk);
			osc_restart <= 1'b0;
			n = 0;
			tick(1);
			while (osc_stable !== 1'b1 && n < 20000) begin
				tick(1);
				n++;
			end
			if (k == 0) base = n - 2;
			chk(32'(n - base), 32'(waits[k]));
		end
		rd(clpc_pkg::ADDR_STAT, rv); chk({31'h0, rv[7]}, 32'h1);
	endtask : t_osc
	task automatic t_div();
		wr(clpc_pkg::ADDR_DIV, 32'h0000_3210);
		count_en();
		chk(32'({ne[0][7:0], ne[1][7:0], ne[2][7:0], ne[3][7:0]}), 32'h4020_1008);
		wr(clpc_pkg::ADDR_DIV, 32'h0000_0123);
		count_en();
		chk(32'({ne[0][7:0], ne[1][7:0], ne[2][7:0], ne[3][7:0]}), 32'h0810_2040);
		wr(clpc_pkg::ADDR_DIV, 32'h0);
	endtask : t_div
	// Bus enable runs every cycle here, so a selected pin toggles 16 times in 16 cycles
	task automatic t_pins(input logic [1:0] sel);
		int tb, ts, lo;
		logic pb, ps;
		wr(clpc_pkg::ADDR_PINS, {30'h0, sel});
		tick(4);
		tb = 0; ts = 0; lo = 0; pb = bclk_pin; ps = sync_memory_clock_pin;
		repeat (16) begin
			tick(1);
			tb += (bclk_pin !== pb);
			ts += (sync_memory_clock_pin !== ps);
			lo += (!sel[0] && bclk_pin !== 1'b1) + (!sel[1] && sync_memory_clock_pin !== 1'b1);
			pb = bclk_pin;
			ps = sync_memory_clock_pin;
		end
		chk(32'(tb), sel[0] ? 32'd16 : 32'd0);
		chk(32'(ts), sel[1] ? 32'd16 : 32'd0);
		chk(32'(lo), 32'h0);
	endtask : t_pins
	task automatic t_opc(input logic [31:0] d, input logic [2:0] exp);
		wr(clpc_pkg::ADDR_OPC, d);
		tick(2);
		chk({29'h0, power_mode}, {29'h0, exp});
	endtask : t_opc
	// Unit vector: cpu, ram, ram bank 2, dma, transfer, flash, usb, wdt, independent_watchdog, timer, osc, hold, irq detect
	task automatic t_lp(input logic [31:0] sby, input logic [2:0] mode, input logic [12:0] units,
		input logic [31:0] mods);
		logic seen;
		wr(clpc_pkg::ADDR_SBY, sby);
		tick(3);
		rd(clpc_pkg::ADDR_STAT, rv); chk({29'h0, rv[2:0]}, 32'h0);
		pulse_wait();
		rd(clpc_pkg::ADDR_STAT, rv); chk({29'h0, rv[2:0]}, {29'h0, mode});
		if (units !== 13'h1fff) begin
			chk({19'h0, cpu_run, ram_en, second_ram_bank_en, dma_unit_en, transfer_controller_en, flash_en, usb_en,
				main_watchdog_en, independent_watchdog_en, eight_bit_timer_en, osc_pll_en, io_hold, irq_detect_en},
				{19'h0, units});
			chk(module_clk_en, mods);
			chk({29'h0, power_mode}, 32'h7);
			chk({28'h0, system_clock_en, peripheral_clock_b_en, bus_clock_en, flash_if_clock_en},
				(mode == 3'h1) ? 32'h7 : 32'h0);
			chk({31'h0, usb_reset}, {31'h0, mode == 3'h2});
		end
		pulse_wait();
		rd(clpc_pkg::ADDR_STAT, rv); chk({29'h0, rv[2:0]}, {29'h0, mode});
		// Interrupt held as a level for seven cycles while the wake-up is watched for
		@(posedge mclk);
		irq_req <= 1'b1;
		seen = 1'b0;
		repeat (6) begin
			tick(1);
			seen |= (cpu_irq_vector === 1'b1);
		end
		@(posedge mclk);
		irq_req <= 1'b0;
		tick(2);
		chk({31'h0, seen & cpu_run}, 32'h1);
		rd(clpc_pkg::ADDR_STAT, rv); chk({29'h0, rv[2:0]}, 32'h0);
	endtask : t_lp
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_pll();
		t_osc();
		t_div();
		t_pins(2'h0);
		t_pins(2'h1);
		t_pins(2'h2);
		t_pins(2'h3);
		t_opc(32'h6, clpc_pkg::OPC_LOW1);
		t_opc(32'h3, clpc_pkg::OPC_LOW1);
		t_opc(32'h7, clpc_pkg::OPC_LOW2);
		wr(clpc_pkg::ADDR_STOP, 32'h0000_00a5);
		tick(2);
		chk(module_clk_en, 32'hffff_ff5a);
		t_lp(32'h0, 3'h1, 13'h0fdd, 32'hffff_ff5a);
		t_lp(32'h2, 3'h2, 13'h001f, 32'h0);
		t_lp(32'h1, 3'h3, 13'h0013, 32'h0);
		t_lp(32'h5, 3'h4, 13'h0003, 32'h0);
		t_opc(32'h0, clpc_pkg::OPC_HIGH);
		finish_test();
	end
endmodule : clpc_top_tb
